// File: dv/ssr_initiator.sv
`timescale 1ns/1ps
module ssr_initiator (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       slow,
	input  wire logic       doutReady,
	input  wire logic       dinValid,
	input  wire logic [7:0] dinByte,
	output logic            cdbValid = 1'b0,
	output logic [7:0]      cdbByte = 8'h00,
	output logic            doutValid = 1'b0,
	output logic [7:0]      doutByte = 8'h00,
	output logic            dinReady = 1'b0
);
	logic [7:0] rxQ[$];
	logic [7:0] txQ[$];

	// ----------------------------------------
	// command bytes, one per edge
	// ----------------------------------------
	task automatic sendCdb(input logic [7:0] b[10], input int n);
		for (int i = 0; i < n; i++)
		begin
			@(posedge mclk);
			cdbValid <= 1'b1;
			cdbByte  <= b[i];
		end
		@(posedge mclk);
		cdbValid <= 1'b0;
		cdbByte  <= ~cdbByte;
	endtask : sendCdb

	// ----------------------------------------
	// list bytes out, data bytes in
	// ----------------------------------------
	// released lines toggle so a stale byte is never mistaken for data
	always @(posedge mclk)
	begin
		if (rst)
		begin
			doutValid <= 1'b0;
			dinReady  <= 1'b0;
		end
		else
		begin
			if (doutValid && doutReady)
				void'(txQ.pop_front());
			doutValid <= (txQ.size() > 0);
			doutByte  <= (txQ.size() > 0) ? txQ[0] : ~doutByte;
			if (dinValid && dinReady)
				rxQ.push_back(dinByte);
			dinReady  <= slow ? ~dinReady : 1'b1;
		end
	end
endmodule : ssr_initiator

// File: dv/ssr_scan_read_bench.sv
`timescale 1ns/1ps
module ssr_scan_read_bench;
	import ssr_pkg::*;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic        slow = 1'b0;
	logic        cdbValid, doutValid, doutReady, dinValid, dinReady;
	logic        pixValid, pixBit, pixReady, imageEnd, duplexEn;
	logic        resvConflict, windowNew, busy, cmdDone, illegalReq;
	logic        senseValid, senseIli, scanStart, frontSel, backSel;
	logic [7:0]  cdbByte, doutByte, dinByte, statusByte, imageWindow;
	logic [15:0] xRes, yRes, winWidth, winLength;
	logic [63:0] paperRec;
	logic [23:0] senseInfo;
	logic [255:0] pixMem;
	logic [31:0] seed = 32'h0000_1086;
	logic [7:0]  c[10];
	logic [7:0]  ex[$];
	int          pIdx, pixLim, scanCnt, miscompares, n_checks;

	always #12.5 mclk = ~mclk;

	ssr_scan_read u_dut (.mclk(mclk), .rst(rst), .cdbValid(cdbValid),
		.cdbByte(cdbByte), .doutValid(doutValid), .doutByte(doutByte),
		.doutReady(doutReady), .dinValid(dinValid), .dinByte(dinByte),
		.dinReady(dinReady), .pixValid(pixValid), .pixBit(pixBit),
		.pixReady(pixReady), .imageEnd(imageEnd), .duplexEn(duplexEn),
		.resvConflict(resvConflict), .windowNew(windowNew), .xRes(xRes),
		.yRes(yRes), .winWidth(winWidth), .winLength(winLength),
		.paperRec(paperRec), .busy(busy), .cmdDone(cmdDone),
		.statusByte(statusByte), .illegalReq(illegalReq),
		.senseValid(senseValid), .senseIli(senseIli), .senseInfo(senseInfo),
		.scanStart(scanStart), .frontSel(frontSel), .backSel(backSel),
		.imageWindow(imageWindow));

	ssr_initiator u_init (.mclk(mclk), .rst(rst), .slow(slow),
		.doutReady(doutReady), .dinValid(dinValid), .dinByte(dinByte),
		.cdbValid(cdbValid), .cdbByte(cdbByte), .doutValid(doutValid),
		.doutByte(doutByte), .dinReady(dinReady));

	// ----------------------------------------
	// pixel source, leftmost pixel of the top raster first
	// ----------------------------------------
	always @(posedge mclk)
	begin
		if (pixValid && pixReady)
		begin
			pIdx     <= pIdx + 1;
			pixBit   <= pixMem[(pIdx + 1) % 256];
			pixValid <= (pIdx + 1 < pixLim);
			imageEnd <= (pIdx + 1 >= pixLim);
		end
		if (!rst)
			scanCnt <= scanCnt + 32'(scanStart);
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction : rnd

	// pixel count along one axis, whole pixels only
	function automatic logic [31:0] pixCnt(input logic [15:0] r,
		input logic [15:0] e);
		return (32'(r) * 32'(e)) / 32'h0000_04b0;
	endfunction : pixCnt

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim

	// bounded wait for the done pulse, then compare the status byte
	task automatic run(input int n, input logic [7:0] st);
		int k;
		k = 0;
		u_init.rxQ.delete();
		u_init.sendCdb(c, n);
		#1;
		chk("busy", 1, 32'(busy));
		do
		begin
			@(posedge mclk);
			#1;
			k++;
		end
		while (cmdDone !== 1'b1 && k < 3000);
		if (cmdDone !== 1'b1)
		begin
			miscompares++;
			end_sim();
		end
		else
		begin
			chk("status", 32'(st), 32'(statusByte));
			chk("idle", 0, 32'(busy));
		end
	endtask : run

	task automatic rd(input logic [7:0] t, input logic [7:0] w,
		input logic [23:0] len, input logic [7:0] st);
		logic [31:0] q;
		q = rnd();
		c = '{OP_READ, 8'h00, t, 8'h00, q[7:0], w, len[23:16], len[15:8],
			len[7:0], 8'h00};
		run(10, st);
	endtask : rd

	task automatic cmpRx();
		chk("data count", ex.size(), u_init.rxQ.size());
		for (int i = 0; i < ex.size() && i < u_init.rxQ.size(); i++)
			chk("data byte", 32'(ex[i]), 32'(u_init.rxQ[i]));
	endtask : cmpRx

	task automatic setPix(input int lim);
		logic [255:0] m;
		for (int i = 0; i < 8; i++)
			m[i*32 +: 32] = rnd();
		@(posedge mclk);
		pixMem   = m;
		pIdx     <= 0;
		pixLim   <= lim;
		pixBit   <= m[0];
		pixValid <= (lim > 0);
		imageEnd <= (lim == 0);
	endtask : setPix

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		logic [31:0] px, py;
		logic [7:0]  w, b;
		logic [7:0]  badTypes[7];
		badTypes = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h7f, 8'h82, 8'hff};
		{pixValid, pixBit, imageEnd, duplexEn, resvConflict, windowNew} = '0;
		{xRes, yRes, winWidth, winLength, paperRec} = '0;
		{pIdx, pixLim, scanCnt, miscompares, n_checks} = '0;
		pixMem = '0;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		// zero-length scan list
		c = '{OP_SCAN, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
			8'h00, 8'h00};
		run(6, ST_GOOD);
		chk("scan start", 1, scanCnt);
		// duplex pair
		u_init.txQ.push_back(WID_FRONT);
		u_init.txQ.push_back(WID_BACK);
		@(posedge mclk);
		duplexEn <= 1'b1;
		c[4] = 8'h02;
		run(6, ST_GOOD);
		chk("front back", 2'b11, {frontSel, backSel});
		// simplex: back face refused, front face alone accepted
		u_init.txQ.push_back(WID_BACK);
		@(posedge mclk);
		duplexEn <= 1'b0;
		c[4] = 8'h01;
		run(6, ST_CHECK);
		chk("illegal back", 1, illegalReq);
		u_init.txQ.push_back(WID_FRONT);
		run(6, ST_GOOD);
		chk("front only", 2'b10, {frontSel, backSel});
		// detected paper record, whole then short
		@(posedge mclk);
		paperRec <= {rnd(), rnd()};
		@(posedge mclk);
		ex.delete();
		for (int i = 0; i < 8; i++)
			ex.push_back(paperRec[63 - 8*i -: 8]);
		w = rnd();
		rd(DT_PAPER, w, 24'h000008, ST_GOOD);
		cmpRx();
		chk("window kept", 0, 32'(imageWindow));
		rd(DT_PAPER, w, 24'h00000b, ST_CHECK);
		cmpRx();
		chk("sense", 32'hc000_0003, {senseValid, senseIli, 6'h00,
			senseInfo});
		// pixel size record for a fresh window
		@(posedge mclk);
		{xRes, yRes} <= rnd();
		{winWidth, winLength} <= rnd();
		windowNew <= 1'b1;
		@(posedge mclk);
		windowNew <= 1'b0;
		px = pixCnt(xRes, winWidth);
		py = pixCnt(yRes, winLength);
		rd(DT_PIXSZ, 8'h00, 24'h000010, ST_GOOD);
		chk("pix count", 16, u_init.rxQ.size());
		for (int i = 0; i < 4 && u_init.rxQ.size() == 16; i++)
		begin
			chk("x pixels", 32'(px[31 - 8*i -: 8]), 32'(u_init.rxQ[i]));
			chk("y pixels", 32'(py[31 - 8*i -: 8]), 32'(u_init.rxQ[i + 4]));
			chk("reserved", 0, 32'(u_init.rxQ[i + 8]));
			chk("reserved", 0, 32'(u_init.rxQ[i + 12]));
		end
		// image read with the initiator stalling
		setPix(256);
		slow = 1'b1;
		w = rnd();
		ex.delete();
		for (int k = 0; k < 24; k++)
		begin
			for (int j = 0; j < 8; j++)
				b[7 - j] = pixMem[8*k + j];
			ex.push_back(b);
		end
		rd(DT_IMAGE, w, 24'h000018, ST_GOOD);
		cmpRx();
		chk("window", 32'(w), 32'(imageWindow));
		slow = 1'b0;
		// pixel size gone once image data was read
		rd(DT_PIXSZ, 8'h00, 24'h000010, ST_CHECK);
		chk("stale residue", 16, 32'(senseInfo));
		chk("stale count", 0, u_init.rxQ.size());
		// image source runs dry after two bytes
		setPix(16);
		rd(DT_IMAGE, 8'h00, 24'h000005, ST_CHECK);
		chk("image short", 32'hc000_0003, {senseValid, senseIli, 6'h00,
			senseInfo});
		chk("short count", 2, u_init.rxQ.size());
		// zero length
		rd(DT_PAPER, 8'h00, 24'h000000, ST_GOOD);
		chk("zero count", 0, u_init.rxQ.size());
		// six-byte read opcode is not the one this block serves
		c[0] = 8'h08;
		run(1, ST_CHECK);
		chk("bad opcode", 1, illegalReq);
		// send-only and reserved data types
		foreach (badTypes[i])
		begin
			rd(badTypes[i], 8'h00, 24'h000004, ST_CHECK);
			chk("bad type", 1, 32'(illegalReq) + u_init.rxQ.size());
		end
		// reservation conflict
		@(posedge mclk);
		resvConflict <= 1'b1;
		rd(DT_PAPER, 8'h00, 24'h000008, ST_CONFLICT);
		chk("conflict count", 0, u_init.rxQ.size());
		@(posedge mclk);
		resvConflict <= 1'b0;
		end_sim();
	end
endmodule : ssr_scan_read_bench

// File: verilog/ssr_pkg.sv
package ssr_pkg;
	// ----------------------------------------
	// command decoding
	// ----------------------------------------
	localparam logic [7:0] OP_SCAN      = 8'h1b;
	localparam logic [7:0] OP_READ      = 8'h28;
	localparam logic [3:0] SCAN_CDB_LEN = 4'h6;
	localparam logic [3:0] READ_CDB_LEN = 4'ha;
	localparam logic [3:0] SCAN_LEN_IDX = 4'h4;
	localparam logic [3:0] READ_TYPE_IDX = 4'h2;
	localparam logic [3:0] READ_WID_IDX = 4'h5;
	localparam logic [3:0] READ_LEN_MSB = 4'h6;
	localparam logic [3:0] READ_LEN_MID = 4'h7;
	localparam logic [3:0] READ_LEN_LSB = 4'h8;

	// ----------------------------------------
	// data types and window identifiers
	// ----------------------------------------
	localparam logic [7:0] DT_IMAGE = 8'h00;
	localparam logic [7:0] DT_PIXSZ = 8'h80;
	localparam logic [7:0] DT_PAPER = 8'h81;
	localparam logic [7:0] WID_FRONT = 8'h00;
	localparam logic [7:0] WID_BACK  = 8'h80;

	// ----------------------------------------
	// status bytes
	// ----------------------------------------
	localparam logic [7:0] ST_GOOD     = 8'h00;
	localparam logic [7:0] ST_CHECK    = 8'h02;
	localparam logic [7:0] ST_CONFLICT = 8'h18;

	// ----------------------------------------
	// records and arithmetic
	// ----------------------------------------
	localparam logic [4:0]  PIXSZ_REC_LEN = 5'h10;
	localparam logic [4:0]  PAPER_REC_LEN = 5'h08;
	localparam logic [4:0]  PIXSZ_COUNT_END = 5'h08;
	localparam logic [11:0] PIX_DIVISOR  = 12'h4b0;
	localparam logic [5:0]  DIV_STEPS    = 6'h20;
	localparam logic [2:0]  PIX_LAST_BIT = 3'h7;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_CDB  = 3'b001,
		ST_LIST = 3'b010,
		ST_CALC = 3'b011,
		ST_XFER = 3'b100,
		ST_STAT = 3'b101
	} ssr_state_t;
endpackage : ssr_pkg

// File: verilog/ssr_scan_read.sv
`timescale 1ns/1ps
// Function
// - scan opcode starts scan, byte4 list length
// - zero list length: no data, no error
// - each list byte selects one window
// - simplex allows only window 00h
// - read type: image, pixel size, paper
// - send-only and reserved types rejected
// - image window id from byte 5
// - qualifier ignored for non-image types
// - three-byte length counts one-byte blocks
// - zero read length ends good, no data
// - short read: check, ILI, valid, residue
// - reservation conflict: status, no data
// - eight pixels per byte, leftmost bit7
// - raster bytes sent top-down, left-right
// - pixel size only before image read
// - pixel count = resolution*extent/1200
// - 16-byte record, X then Y, msb first
module ssr_scan_read
	import ssr_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        cdbValid,
	input  wire logic [7:0]  cdbByte,
	input  wire logic        doutValid,
	input  wire logic [7:0]  doutByte,
	output logic             doutReady,
	output logic             dinValid,
	output logic [7:0]       dinByte,
	input  wire logic        dinReady,
	input  wire logic        pixValid,
	input  wire logic        pixBit,
	output logic             pixReady,
	input  wire logic        imageEnd,
	input  wire logic        duplexEn,
	input  wire logic        resvConflict,
	input  wire logic        windowNew,
	input  wire logic [15:0] xRes,
	input  wire logic [15:0] yRes,
	input  wire logic [15:0] winWidth,
	input  wire logic [15:0] winLength,
	input  wire logic [63:0] paperRec,
	output logic             busy,
	output logic             cmdDone,
	output logic [7:0]       statusByte,
	output logic             illegalReq,
	output logic             senseValid,
	output logic             senseIli,
	output logic [23:0]      senseInfo,
	output logic             scanStart,
	output logic             frontSel,
	output logic             backSel,
	output logic [7:0]       imageWindow
);
	import ssr_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	ssr_state_t state_reg;
	logic [3:0]  cdbIdx_reg;
	logic [7:0]  opcode_reg;
	logic [7:0]  dataType_reg;
	logic [7:0]  listLen_reg;
	logic [23:0] remain_reg;
	logic [4:0]  recIdx_reg;
	logic [7:0]  pixShift_reg;
	logic [2:0]  bitCnt_reg;
	logic [5:0]  divCnt_reg;
	logic        pxAvail_reg;
	logic        busy_reg;
	logic        badId_reg;
	logic        dinValid_reg;
	logic [7:0]  dinByte_reg;
	logic        pixReady_reg;
	logic        doutReady_reg;
	logic        cmdDone_reg;
	logic [7:0]  statusByte_reg;
	logic        illegalReq_reg;
	logic        senseValid_reg;
	logic [23:0] senseInfo_reg;
	logic        scanStart_reg;
	logic        frontSel_reg;
	logic        backSel_reg;
	logic [7:0]  imageWindow_reg;
	logic [31:0] pxCount [2];

	logic cdbLast;
	logic byteTaken;
	logic pixTaken;
	logic listTaken;
	logic isImage;
	logic isRecord;
	logic [4:0]  recLen;
	logic [63:0] recWord;
	logic [7:0]  recByte;
	logic        recEmpty;
	logic        imgDry;
	logic        pixReady_next;

	assign cdbLast = cdbValid && (state_reg == ST_CDB)
		&& (cdbIdx_reg == ((opcode_reg == OP_SCAN) ? SCAN_CDB_LEN
		: READ_CDB_LEN) - 4'h1);
	assign byteTaken = dinValid_reg && dinReady;
	assign pixTaken  = pixValid && pixReady_reg;
	assign listTaken = doutValid && doutReady_reg;
	assign isImage   = (dataType_reg == DT_IMAGE);
	assign isRecord  = (dataType_reg == DT_PIXSZ)
		|| (dataType_reg == DT_PAPER);
	// a record asked for when stale counts as zero bytes available
	assign recLen = (dataType_reg == DT_PAPER) ? PAPER_REC_LEN
		: (pxAvail_reg ? PIXSZ_REC_LEN : 5'h00);
	assign recWord = (dataType_reg == DT_PAPER) ? paperRec
		: {pxCount[0], pxCount[1]};
	assign recByte = (recIdx_reg >= PIXSZ_COUNT_END
		&& dataType_reg == DT_PIXSZ) ? 8'h00
		: 8'(recWord >> {~recIdx_reg[2:0], 3'h0});
	assign recEmpty = (recIdx_reg >= recLen);
	// a source that stops mid-byte drops the partial byte, never hangs
	assign imgDry   = imageEnd && !pixTaken;
	assign pixReady_next = (state_reg == ST_XFER) && isImage
		&& !dinValid_reg && (remain_reg != 24'h0)
		&& !(pixTaken && bitCnt_reg == PIX_LAST_BIT) && !imageEnd;

	// ----------------------------------------
	// pixel count dividers, one per axis
	// ----------------------------------------
	genvar ax;
	generate
		for (ax = 0; ax < 2; ax++)
		begin : g_axis
			logic [31:0] dvd_reg;
			logic [31:0] quo_reg;
			logic [11:0] rem_reg;
			logic [11:0] trial;
			logic [31:0] prod;
			assign prod = (ax == 0) ? xRes * winWidth
				: yRes * winLength;
			assign trial = {rem_reg[10:0], dvd_reg[31]};
			assign pxCount[ax] = quo_reg;
			always_ff @(posedge mclk)
			begin
				if (rst)
				begin
					dvd_reg <= 32'h0;
					quo_reg <= 32'h0;
					rem_reg <= 12'h0;
				end
				else if (state_reg == ST_CDB && cdbLast)
				begin
					dvd_reg <= prod;
					quo_reg <= 32'h0;
					rem_reg <= 12'h0;
				end
				else if (state_reg == ST_CALC)
				begin
					// restoring division, one quotient bit a cycle
					dvd_reg <= {dvd_reg[30:0], 1'b0};
					if (trial >= PIX_DIVISOR)
					begin
						rem_reg <= trial - PIX_DIVISOR;
						quo_reg <= {quo_reg[30:0], 1'b1};
					end
					else
					begin
						rem_reg <= trial;
						quo_reg <= {quo_reg[30:0], 1'b0};
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// command sequencing
	// ----------------------------------------
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			state_reg  <= ST_IDLE;
			cdbIdx_reg <= 4'h0;
			opcode_reg <= 8'h00;
			divCnt_reg <= 6'h0;
			busy_reg   <= 1'b0;
		end
		else
		begin
			unique case (state_reg)
				ST_IDLE:
					if (cdbValid)
					begin
						opcode_reg <= cdbByte;
						cdbIdx_reg <= 4'h1;
						busy_reg   <= 1'b1;
						if (cdbByte == OP_SCAN || cdbByte == OP_READ)
							state_reg <= ST_CDB;
						else
							state_reg <= ST_STAT;
					end
				ST_CDB:
					if (cdbValid)
					begin
						cdbIdx_reg <= cdbIdx_reg + 4'h1;
						if (cdbLast)
							state_reg <= ST_STAT;
						if (cdbLast && opcode_reg == OP_SCAN
							&& listLen_reg != 8'h00)
							state_reg <= ST_LIST;
						if (cdbLast && opcode_reg == OP_READ
							&& !resvConflict && dataType_reg == DT_PIXSZ)
						begin
							state_reg  <= ST_CALC;
							divCnt_reg <= 6'h0;
						end
						else if (cdbLast && opcode_reg == OP_READ
							&& !resvConflict && (isImage || isRecord)
							&& remain_reg != 24'h0)
							state_reg <= ST_XFER;
					end
				ST_LIST:
					if (listTaken && listLen_reg == 8'h01)
						state_reg <= ST_STAT;
				ST_CALC:
				begin
					divCnt_reg <= divCnt_reg + 6'h1;
					if (divCnt_reg == DIV_STEPS - 6'h1)
						state_reg <= (remain_reg == 24'h0) ? ST_STAT
							: ST_XFER;
				end
				ST_XFER:
					if (!dinValid_reg && (remain_reg == 24'h0
						|| (isRecord && recEmpty) || (isImage && imgDry)))
						state_reg <= ST_STAT;
				ST_STAT:
				begin
					state_reg <= ST_IDLE;
					busy_reg  <= 1'b0;
				end
				default:
				begin
					state_reg <= ST_IDLE;
					busy_reg  <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// command field capture
	// ----------------------------------------
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			dataType_reg    <= 8'h00;
			listLen_reg     <= 8'h00;
			remain_reg      <= 24'h0;
			imageWindow_reg <= 8'h00;
		end
		else if (state_reg == ST_CDB && cdbValid)
		begin
			if (opcode_reg == OP_SCAN && cdbIdx_reg == SCAN_LEN_IDX)
				listLen_reg <= cdbByte;
			if (opcode_reg == OP_READ)
			begin
				if (cdbIdx_reg == READ_TYPE_IDX)
					dataType_reg <= cdbByte;
				// qualifier byte 5 is the window id, kept for image reads only
				if (cdbIdx_reg == READ_WID_IDX && isImage)
					imageWindow_reg <= cdbByte;
				if (cdbIdx_reg == READ_LEN_MSB)
					remain_reg[23:16] <= cdbByte;
				if (cdbIdx_reg == READ_LEN_MID)
					remain_reg[15:8] <= cdbByte;
				if (cdbIdx_reg == READ_LEN_LSB)
					remain_reg[7:0] <= cdbByte;
			end
		end
		else
		begin
			if (listTaken)
				listLen_reg <= listLen_reg - 8'h01;
			if (byteTaken)
				remain_reg <= remain_reg - 24'h1;
		end
	end

	// ----------------------------------------
	// window identifier list
	// ----------------------------------------
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			frontSel_reg  <= 1'b0;
			backSel_reg   <= 1'b0;
			badId_reg     <= 1'b0;
			doutReady_reg <= 1'b0;
			scanStart_reg <= 1'b0;
		end
		else
		begin
			scanStart_reg <= cdbLast && opcode_reg == OP_SCAN;
			doutReady_reg <= (state_reg == ST_LIST)
				&& !(listTaken && listLen_reg == 8'h01);
			if (cdbLast && opcode_reg == OP_SCAN)
			begin
				frontSel_reg <= 1'b0;
				backSel_reg  <= 1'b0;
				badId_reg    <= 1'b0;
			end
			else if (listTaken)
			begin
				if (doutByte == WID_FRONT)
					frontSel_reg <= 1'b1;
				else if (doutByte == WID_BACK && duplexEn)
					backSel_reg <= 1'b1;
				else
					badId_reg <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// data in path: packing and records
	// ----------------------------------------
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			dinValid_reg <= 1'b0;
			dinByte_reg  <= 8'h00;
			pixShift_reg <= 8'h00;
			bitCnt_reg   <= 3'h0;
			recIdx_reg   <= 5'h00;
			pixReady_reg <= 1'b0;
		end
		else
		begin
			pixReady_reg <= pixReady_next;
			if (state_reg == ST_CDB)
			begin
				recIdx_reg <= 5'h00;
				bitCnt_reg <= 3'h0;
			end
			if (byteTaken)
				dinValid_reg <= 1'b0;
			// image bytes leave in source order: top raster first
			if (pixTaken)
			begin
				pixShift_reg <= {pixShift_reg[6:0], pixBit};
				bitCnt_reg   <= bitCnt_reg + 3'h1;
				if (bitCnt_reg == PIX_LAST_BIT)
				begin
					dinByte_reg  <= {pixShift_reg[6:0], pixBit};
					dinValid_reg <= 1'b1;
				end
			end
			// one idle cycle between record bytes keeps the index simple
			if (state_reg == ST_XFER && isRecord && !dinValid_reg
				&& remain_reg != 24'h0 && !recEmpty)
			begin
				dinByte_reg  <= recByte;
				dinValid_reg <= 1'b1;
				recIdx_reg   <= recIdx_reg + 5'h01;
			end
		end
	end

	// ----------------------------------------
	// pixel size freshness
	// ----------------------------------------
	always_ff @(posedge mclk)
	begin
		if (rst)
			pxAvail_reg <= 1'b0;
		else if (windowNew)
			pxAvail_reg <= 1'b1;
		else if (byteTaken && isImage && state_reg == ST_XFER)
			pxAvail_reg <= 1'b0;
	end

	// ----------------------------------------
	// completion status and sense
	// ----------------------------------------
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			cmdDone_reg    <= 1'b0;
			statusByte_reg <= ST_GOOD;
			illegalReq_reg <= 1'b0;
			senseValid_reg <= 1'b0;
			senseInfo_reg  <= 24'h0;
		end
		else
		begin
			cmdDone_reg <= (state_reg == ST_STAT);
			if (state_reg == ST_STAT)
			begin
				statusByte_reg <= ST_GOOD;
				illegalReq_reg <= 1'b0;
				senseValid_reg <= 1'b0;
				senseInfo_reg  <= 24'h0;
				if (opcode_reg == OP_READ && resvConflict)
					statusByte_reg <= ST_CONFLICT;
				else if ((opcode_reg != OP_SCAN && opcode_reg != OP_READ)
					|| (opcode_reg == OP_SCAN && badId_reg)
					|| (opcode_reg == OP_READ && !isImage && !isRecord))
				begin
					statusByte_reg <= ST_CHECK;
					illegalReq_reg <= 1'b1;
				end
				else if (opcode_reg == OP_READ && remain_reg != 24'h0)
				begin
					statusByte_reg <= ST_CHECK;
					senseValid_reg <= 1'b1;
					senseInfo_reg  <= remain_reg;
				end
			end
		end
	end

	assign doutReady   = doutReady_reg;
	assign dinValid    = dinValid_reg;
	assign dinByte     = dinByte_reg;
	assign pixReady    = pixReady_reg;
	assign busy        = busy_reg;
	assign cmdDone     = cmdDone_reg;
	assign statusByte  = statusByte_reg;
	assign illegalReq  = illegalReq_reg;
	assign senseValid  = senseValid_reg;
	assign senseIli    = senseValid_reg;
	assign senseInfo   = senseInfo_reg;
	assign scanStart   = scanStart_reg;
	assign frontSel    = frontSel_reg;
	assign backSel     = backSel_reg;
	assign imageWindow = imageWindow_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_scan_starts: assert property (@(posedge mclk) disable iff (rst)
		cdbLast && opcode_reg == OP_SCAN |=> scanStart)
		else $error("scan start pulse missing");
	a_zero_list: assert property (@(posedge mclk) disable iff (rst)
		cdbLast && opcode_reg == OP_SCAN && listLen_reg == 8'h00
		|=> !doutReady ##1 cmdDone && statusByte == ST_GOOD)
		else $error("zero list length mishandled");
	a_simplex_back: assert property (@(posedge mclk) disable iff (rst)
		listTaken && doutByte == WID_BACK && !duplexEn |=> !$rose(backSel))
		else $error("back face accepted in simplex");
	a_reserved_type: assert property (@(posedge mclk) disable iff (rst)
		cmdDone && opcode_reg == OP_READ && !isImage && !isRecord
		&& !resvConflict |-> statusByte == ST_CHECK && illegalReq)
		else $error("reserved data type not rejected");
	a_conflict_nodata: assert property (@(posedge mclk) disable iff (rst)
		cdbLast && opcode_reg == OP_READ && resvConflict
		|=> !dinValid ##1 cmdDone && statusByte == ST_CONFLICT)
		else $error("conflict did not end read");
	a_short_residue: assert property (@(posedge mclk) disable iff (rst)
		state_reg == ST_STAT && opcode_reg == OP_READ && !resvConflict
		&& (isImage || isRecord) && remain_reg != 24'h0
		|=> senseValid && senseIli && senseInfo == $past(remain_reg))
		else $error("short read sense wrong");
	a_pixel_pack: assert property (@(posedge mclk) disable iff (rst)
		pixTaken && bitCnt_reg == PIX_LAST_BIT
		|=> dinValid && dinByte[0] == $past(pixBit)
		&& dinByte[7] == $past(pixShift_reg[6]))
		else $error("pixel packing order wrong");
	a_pixsz_stale: assert property (@(posedge mclk) disable iff (rst)
		byteTaken && isImage && state_reg == ST_XFER && !windowNew
		|=> !pxAvail_reg)
		else $error("pixel size still offered after image");
	a_pixsz_msb: assert property (@(posedge mclk) disable iff (rst)
		state_reg == ST_XFER && dataType_reg == DT_PIXSZ && pxAvail_reg
		&& !dinValid_reg && remain_reg != 24'h0 && recIdx_reg == 5'h00
		|=> dinByte == pxCount[0][31:24])
		else $error("pixel size record not msb first");
endmodule : ssr_scan_read
